//--- src/fuse_config_decoder.sv
// Reset-time loader and decoder for the nonvolatile configuration bytes
//
// Decided for this implementation: the Wishbone slave port.
`include "fuse_config_defines.svh"

module fuse_config_decoder (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic lf_clk_i,
    // Nonvolatile store
    output logic [3:0] nv_addr_o,
    output logic nv_rd_o,
    input wire logic [7:0] nv_data_i,
    input wire logic nv_valid_i,
    // Factory calibration sets
    input wire fuse_config_pkg::cal_set_s cal_16m_i,
    input wire fuse_config_pkg::cal_set_s cal_20m_i,
    // Classic Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Decoded outputs
    output fuse_config_pkg::osc_setup_s osc_o,
    output fuse_config_pkg::timer_setup_s timer_o,
    input wire logic [3:0] compare_raw_i,
    input wire logic fault_detect_flag_i,
    input wire logic debug_entry_i,
    output logic [3:0] compare_pin_o,
    output logic [3:0] compare_pin_oe_o,
    output fuse_config_pkg::crc_scan_source_e crc_scan_source_o,
    output fuse_config_pkg::reset_pin_function_e reset_pin_function_o,
    output logic gpio_drive_allow_o,
    input wire logic chip_erase_i,
    output logic eeprom_erase_o,
    output logic [2:0] startup_delay_select_o,
    output logic startup_done_o,
    output fuse_config_pkg::flash_map_s flash_map_o,
    output logic device_locked_o,
    input wire logic prog_bus_req_i,
    output logic prog_bus_grant_o,
    output logic load_done_o
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [25:0] sut_cycles(input logic [2:0] code);
        logic [25:0] ms;
        ms = 26'h0000000;
        if (code != 3'h0) begin
            ms = 26'h0000001 << (code - 3'h1);
        end
        sut_cycles = 26'(ms * 26'(`MS_CYCLES));
    endfunction

    function automatic logic is_open(input logic [7:0] code);
        is_open = (code == `OPEN_CODE);
    endfunction

    // ----------------------------------------
    // Load sequencer
    // ----------------------------------------
    fuse_config_pkg::load_state_e state_reg;
    fuse_config_pkg::load_state_e state_next;
    logic [3:0] idx_reg;
    logic por_pending_reg;
    logic [7:0] osc_byte_reg;
    logic [7:0] tmr_byte_reg;
    logic [7:0] sys_a_reg;
    logic [7:0] sys_b_reg;
    logic [7:0] app_reg;
    logic [7:0] boot_reg;
    logic [7:0] lock_reg;
    logic last_idx;
    logic take_byte;

    assign last_idx = (idx_reg == 4'(`FUSE_COUNT - 1));
    assign take_byte = (state_reg == fuse_config_pkg::LD_WAIT) && nv_valid_i;
    assign nv_addr_o = idx_reg;
    assign nv_rd_o = (state_reg == fuse_config_pkg::LD_READ);
    assign load_done_o = (state_reg == fuse_config_pkg::LD_DONE);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            fuse_config_pkg::LD_IDLE: state_next = fuse_config_pkg::LD_READ;
            fuse_config_pkg::LD_READ: state_next = fuse_config_pkg::LD_WAIT;
            fuse_config_pkg::LD_WAIT: begin
                if (nv_valid_i) begin
                    state_next = last_idx ? fuse_config_pkg::LD_DONE : fuse_config_pkg::LD_READ;
                end
            end
            fuse_config_pkg::LD_DONE: state_next = fuse_config_pkg::LD_DONE;
            default: state_next = fuse_config_pkg::LD_IDLE;
        endcase
    end

    // ----------------------------------------
    // Wishbone decode
    // ----------------------------------------
    logic ack_reg;
    logic stage_reg;
    logic [31:0] dat_reg;
    logic req;
    logic wr_req;
    logic [3:0] word_idx;
    logic fuse_space;
    logic lock_write;
    logic [31:0] rd_word;
    logic [7:0] shadow_rdata;

    // Two wait states: shadow read data is registered, so it trails the address by a cycle
    assign req = cyc_i && stb_i && !ack_reg;
    // Write lands on the edge at which the master sees ack
    assign wr_req = cyc_i && stb_i && we_i && ack_reg;
    assign word_idx = adr_i[5:2];
    // Shadow words past the fuse count fall outside fuse space, so they read as zero
    assign fuse_space = (adr_i[7:6] == 2'h0) && (adr_i[1:0] == 2'h0) && (word_idx < 4'(`FUSE_COUNT));
    // Only the lock byte accepts writes, and only after loading
    assign lock_write = wr_req && fuse_space && sel_i[0] && load_done_o
        && (word_idx == `LOCK_IDX);
    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

    // Shadow keeps a readable copy of every fuse byte
    fuse_shadow_mem u_shadow (
        .clk_i(clk_i),
        .we_i(take_byte || lock_write),
        .waddr_i(lock_write ? `LOCK_IDX : idx_reg),
        .wdata_i(lock_write ? dat_i[7:0] : nv_data_i),
        .raddr_i(word_idx),
        .rdata_o(shadow_rdata)
    );

    // ----------------------------------------
    // Decoded fields
    // ----------------------------------------
    logic [1:0] freq_code;
    fuse_config_pkg::cal_set_s cal_pick;
    logic locked;
    logic [25:0] sut_count_reg;
    logic sut_done_reg;
    logic gpio_hold;
    logic [3:0] default_level_reg;

    assign freq_code = osc_byte_reg[`FREQ_LSB +: 2];
    assign cal_pick = (freq_code == `FREQ_16M) ? cal_16m_i : cal_20m_i;
    assign locked = !is_open(lock_reg);

    assign osc_o.osc_cal_write_lock = osc_byte_reg[`OSC_LOCK_BIT];
    assign osc_o.osc_frequency_choice = freq_code;
    assign osc_o.freq_reserved = (freq_code != `FREQ_16M) && (freq_code != `FREQ_20M);
    assign osc_o.coarse_cal_value = cal_pick.coarse;
    assign osc_o.temp_cal_value = cal_pick.temp;

    assign timer_o = tmr_byte_reg;
    // Default level replaces the compare value until loaded or in faulted debug
    assign compare_pin_o = (!load_done_o || (debug_entry_i && fault_detect_flag_i))
        ? tmr_byte_reg[3:0] : compare_raw_i;
    assign compare_pin_oe_o = load_done_o ? tmr_byte_reg[7:4] : 4'h0;

    assign crc_scan_source_o = fuse_config_pkg::crc_scan_source_e'(sys_a_reg[`CRC_LSB +: 2]);
    assign reset_pin_function_o = fuse_config_pkg::reset_pin_function_e'(sys_a_reg[`RSTPIN_LSB +: 2]);
    assign gpio_drive_allow_o = load_done_o && !gpio_hold
        && (reset_pin_function_o == fuse_config_pkg::PIN_GPIO);
    // Treated as locked while loading, so erase never trusts a stale retain bit
    assign eeprom_erase_o = chip_erase_i && (device_locked_o || !sys_a_reg[`EEPROM_RETAIN_ON_ERASE_BIT]);
    assign startup_delay_select_o = sys_b_reg[`SUT_LSB +: 3];
    assign startup_done_o = sut_done_reg;

    assign flash_map_o.boot_end_block = boot_reg;
    assign flash_map_o.app_end_block = app_reg;
    assign flash_map_o.whole_flash_boot = (boot_reg == 8'h00);
    assign flash_map_o.no_app_data = (app_reg == 8'h00);

    // Locked until the lock byte is known, so nothing leaks early
    assign device_locked_o = locked || !load_done_o;
    assign prog_bus_grant_o = prog_bus_req_i && !device_locked_o;

    gpio_hold_timer u_hold (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .lf_clk_i(lf_clk_i),
        .hold_o(gpio_hold)
    );

    assign rd_word = (adr_i == `STATUS_ADDR) ? {26'h0, gpio_hold, sut_done_reg, locked,
            osc_o.freq_reserved, load_done_o, por_pending_reg}
        : (adr_i == `CAL_ADDR) ? {21'h0, cal_pick}
        : (adr_i == `CTRL_ADDR) ? {28'h0, default_level_reg}
        : fuse_space ? {24'h0, shadow_rdata} : 32'h0;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= fuse_config_pkg::LD_IDLE;
            idx_reg <= 4'h0;
            sut_count_reg <= 26'h0;
            sut_done_reg <= 1'b0;
            ack_reg <= 1'b0;
            stage_reg <= 1'b0;
            dat_reg <= 32'h0;
            if (por_i) begin
                por_pending_reg <= 1'b1;
            end
        end else begin
            state_reg <= state_next;
            stage_reg <= req && !stage_reg;
            ack_reg <= req && stage_reg;
            dat_reg <= req && stage_reg && !we_i ? rd_word : 32'h0;
            if (take_byte) begin
                idx_reg <= idx_reg + 4'h1;
                if (last_idx) begin
                    por_pending_reg <= 1'b0;
                end
            end
            if (load_done_o && !sut_done_reg) begin
                sut_count_reg <= sut_count_reg + 26'h1;
                if (sut_count_reg >= sut_cycles(startup_delay_select_o)) begin
                    sut_done_reg <= 1'b1;
                end
            end
        end
    end

    // Captured bytes; held until the next load, the timer byte until the next power-on load, the lock byte also taking bus writes
    always_ff @(posedge clk_i) begin
        if (rst_i && por_i) begin
            sys_a_reg <= `SYS_CFG_A_RESET;
        end
        if (take_byte) begin
            case (idx_reg)
                `OSC_CFG_IDX: osc_byte_reg <= nv_data_i;
                `TMR_CFG_IDX: begin
                    if (por_pending_reg) begin
                        tmr_byte_reg <= nv_data_i;
                    end
                end
                `SYS_CFG_A_IDX: sys_a_reg <= nv_data_i;
                `SYS_CFG_B_IDX: sys_b_reg <= nv_data_i;
                `APP_END_IDX: app_reg <= nv_data_i;
                `BOOT_END_IDX: boot_reg <= nv_data_i;
                `LOCK_IDX: lock_reg <= nv_data_i;
                default: ;
            endcase
        end else if (lock_write) begin
            lock_reg <= dat_i[7:0];
        end
        default_level_reg <= tmr_byte_reg[3:0];
        if (rst_i && por_i) begin
            osc_byte_reg <= 8'h00;
            tmr_byte_reg <= 8'h00;
            sys_b_reg <= 8'h00;
            app_reg <= 8'h00;
            boot_reg <= 8'h00;
            lock_reg <= 8'h00;
            default_level_reg <= 4'h0;
        end
    end
endmodule

//--- src/fuse_config_defines.svh
// Offsets, field positions, reset values and timing counts of the fuse decoder
`ifndef FUSE_CONFIG_DEFINES_SVH
`define FUSE_CONFIG_DEFINES_SVH

// ----------------------------------------
// Fuse indices, byte address is four times
// ----------------------------------------
`define OSC_CFG_IDX 4'h2
`define TMR_CFG_IDX 4'h4
`define SYS_CFG_A_IDX 4'h5
`define SYS_CFG_B_IDX 4'h6
`define APP_END_IDX 4'h7
`define BOOT_END_IDX 4'h8
`define LOCK_IDX 4'hA
`define FUSE_COUNT 11

// ----------------------------------------
// Extra registers
// ----------------------------------------
`define STATUS_ADDR 8'h40
`define CTRL_ADDR 8'h44
`define CAL_ADDR 8'h48

// ----------------------------------------
// Field positions
// ----------------------------------------
`define OSC_LOCK_BIT 7
`define FREQ_LSB 0
`define CRC_LSB 6
`define RSTPIN_LSB 2
`define EEPROM_RETAIN_ON_ERASE_BIT 0
`define SUT_LSB 0

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define FREQ_16M 2'h1
`define FREQ_20M 2'h2
`define OPEN_CODE 8'hC5
`define SYS_CFG_A_RESET 8'hC4

// ----------------------------------------
// Timing
// ----------------------------------------
`define GPIO_HOLD_LF_CYCLES 768
`define CLK_HZ 20000000
`define MS_CYCLES (`CLK_HZ / 1000)

`endif

//--- src/fuse_config_pkg.sv
// Types shared by the fuse decoder files
package fuse_config_pkg;

    typedef enum logic [1:0] {
        CRC_FULL_FLASH = 2'b00,
        CRC_BOOT_ONLY = 2'b01,
        CRC_BOOT_APP = 2'b10,
        CRC_DISABLED = 2'b11
    } crc_scan_source_e;

    typedef enum logic [1:0] {
        PIN_GPIO = 2'b00,
        PIN_PROG = 2'b01,
        PIN_RESET = 2'b10,
        PIN_RSVD = 2'b11
    } reset_pin_function_e;

    typedef enum logic [1:0] {
        LD_IDLE = 2'b00,
        LD_READ = 2'b01,
        LD_WAIT = 2'b10,
        LD_DONE = 2'b11
    } load_state_e;

    typedef struct packed {
        logic osc_cal_write_lock;
        logic [1:0] osc_frequency_choice;
        logic freq_reserved;
        logic [6:0] coarse_cal_value;
        logic [3:0] temp_cal_value;
    } osc_setup_s;

    typedef struct packed {
        logic [3:0] compare_pin_enable;
        logic [3:0] compare_default_level;
    } timer_setup_s;

    typedef struct packed {
        logic [7:0] boot_end_block;
        logic [7:0] app_end_block;
        logic whole_flash_boot;
        logic no_app_data;
    } flash_map_s;

    typedef struct packed {
        logic [6:0] coarse;
        logic [3:0] temp;
    } cal_set_s;

endpackage

//--- src/fuse_shadow_mem.sv
// Small shadow memory holding the loaded fuse bytes
module fuse_shadow_mem (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [3:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [3:0] raddr_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:15];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule

//--- src/gpio_hold_timer.sv
// Counts low-frequency cycles after reset before the shared pin may drive
module gpio_hold_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic lf_clk_i,
    output logic hold_o
);
    logic lf_s1_reg;
    logic lf_s2_reg;
    logic lf_s3_reg;
    logic [9:0] count_reg;
    logic lf_rise;

    // Pin clock is foreign: two flops before the edge detector
    assign lf_rise = lf_s2_reg & ~lf_s3_reg;
    assign hold_o = (count_reg != 10'(`GPIO_HOLD_LF_CYCLES));

    always_ff @(posedge clk_i) begin
        lf_s1_reg <= lf_clk_i;
        lf_s2_reg <= lf_s1_reg;
        lf_s3_reg <= lf_s2_reg;
        if (rst_i) begin
            count_reg <= 10'h000;
        end else if (lf_rise && hold_o) begin
            count_reg <= count_reg + 10'h001;
        end
    end
endmodule

//--- verif/fuse_config_chk.sv
// Port checks for the fuse decoder
module fuse_config_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic prog_bus_req_i,
    input wire logic prog_bus_grant_o,
    input wire logic device_locked_o,
    input wire logic chip_erase_i,
    input wire logic eeprom_erase_o,
    input wire logic load_done_o,
    input wire logic [3:0] compare_raw_i,
    input wire logic [3:0] compare_pin_o,
    input wire logic [3:0] compare_pin_oe_o,
    input wire logic debug_entry_i,
    input wire logic fault_detect_flag_i,
    input wire logic gpio_drive_allow_o,
    input wire fuse_config_pkg::reset_pin_function_e reset_pin_function_o,
    input wire fuse_config_pkg::osc_setup_s osc_o,
    input wire fuse_config_pkg::timer_setup_s timer_o
);
    // ----------------------------------------
    // Clocking
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sequence req_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence pulse_s;
        ack_o ##1 !ack_o;
    endsequence
    wire faulted = debug_entry_i && fault_detect_flag_i;

    ack_pulse_a: assert property ($rose(cyc_i && stb_i) |-> req_s ##1 req_s ##1 pulse_s)
        else $error("bus answer wrong");
    bus_grant_a: assert property (prog_bus_grant_o == (prog_bus_req_i && !device_locked_o))
        else $error("grant wrong");
    locked_erase_a: assert property (chip_erase_i && device_locked_o |-> eeprom_erase_o)
        else $error("locked erase kept eeprom");
    idle_erase_a: assert property (!chip_erase_i |-> !eeprom_erase_o) else $error("erase without request");
    locked_start_a: assert property ($fell(rst_i) |-> device_locked_o && !load_done_o)
        else $error("open before load");
    pin_default_a: assert property (!load_done_o || faulted |-> compare_pin_o == timer_o.compare_default_level)
        else $error("default level wrong");
    pin_live_a: assert property (load_done_o && !faulted |-> compare_pin_o == compare_raw_i
        && compare_pin_oe_o == timer_o.compare_pin_enable) else $error("pin gate wrong");
    gpio_func_a: assert property (gpio_drive_allow_o |-> load_done_o
        && reset_pin_function_o == fuse_config_pkg::PIN_GPIO) else $error("pin driven off gpio");
    gpio_hold_a: assert property ($rose(load_done_o) |-> !gpio_drive_allow_o [*8]) else $error("hold skipped");
    fuse_stable_a: assert property (load_done_o && $past(load_done_o) |-> $stable(osc_o) && $stable(timer_o))
        else $error("fuse value moved");
endmodule

bind fuse_config_decoder fuse_config_chk fuse_config_chk_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .prog_bus_req_i(prog_bus_req_i), .prog_bus_grant_o(prog_bus_grant_o),
    .device_locked_o(device_locked_o), .chip_erase_i(chip_erase_i), .eeprom_erase_o(eeprom_erase_o),
    .load_done_o(load_done_o), .compare_raw_i(compare_raw_i), .compare_pin_o(compare_pin_o),
    .compare_pin_oe_o(compare_pin_oe_o), .debug_entry_i(debug_entry_i), .fault_detect_flag_i(fault_detect_flag_i),
    .gpio_drive_allow_o(gpio_drive_allow_o), .reset_pin_function_o(reset_pin_function_o), .osc_o(osc_o),
    .timer_o(timer_o));

//--- verif/nv_store_model.sv
// Nonvolatile store model answering byte reads after a set stall
module nv_store_model (
    input wire logic clk_i,
    input wire logic rd_i,
    input wire logic [3:0] addr_i,
    input wire logic [10:0][7:0] bytes_i,
    input wire logic [3:0] delay_i,
    output logic [7:0] data_o,
    output logic valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy = 1'b0;
    logic [3:0] cnt = 4'h0;
    logic [7:0] last = 8'h00;
    initial valid_o = 1'b0;
    initial data_o = 8'h00;
    // Idle data shows the inverse, so a late sample never matches by luck
    always @(posedge clk_i) begin
        valid_o <= 1'b0;
        data_o <= ~last;
        if (rd_i) begin
            busy <= 1'b1;
            cnt <= delay_i;
        end else if (busy && cnt == 4'h0) begin
            busy <= 1'b0;
            valid_o <= 1'b1;
            data_o <= bytes_i[addr_i];
            last <= bytes_i[addr_i];
        end else if (busy) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule

//--- verif/tb.sv
// Testbench for the fuse decoder
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, lf_clk_i = 1'b0;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, nv_rd_o, nv_valid_i;
    logic [7:0] adr_i = 8'h00, nv_data_i;
    logic [3:0] sel_i = 4'h0, nv_addr_o, compare_pin_o, compare_pin_oe_o, dly = 4'h2;
    logic [3:0] compare_raw_i = 4'hF;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic fault_detect_flag_i = 1'b0, debug_entry_i = 1'b0, chip_erase_i = 1'b0, prog_bus_req_i = 1'b1;
    logic gpio_drive_allow_o, eeprom_erase_o, startup_done_o, device_locked_o, prog_bus_grant_o, load_done_o;
    logic [2:0] startup_delay_select_o;
    fuse_config_pkg::cal_set_s cal_16m_i = {7'h15, 4'h3}, cal_20m_i = {7'h6A, 4'hC};
    fuse_config_pkg::osc_setup_s osc_o;
    fuse_config_pkg::timer_setup_s timer_o;
    fuse_config_pkg::crc_scan_source_e crc_scan_source_o;
    fuse_config_pkg::reset_pin_function_e reset_pin_function_o;
    fuse_config_pkg::flash_map_s flash_map_o;
    logic [10:0][7:0] fz = {8'hC5, 8'h77, 8'h10, 8'h20, 8'h00, 8'h01, 8'hA5, 8'h99, 8'h82, 8'h3C, 8'h5A};
    int err_count = 0, n_checks = 0, cyc_n = 0, t0 = 0, n;

    always #25 clk_i = ~clk_i;
    // Slow clock, 8 system cycles a period, wide enough for the synchroniser
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n % 4 == 3) lf_clk_i <= ~lf_clk_i;
    end

    fuse_config_decoder fuse_config_decoder_i (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .lf_clk_i(lf_clk_i),
        .nv_addr_o(nv_addr_o), .nv_rd_o(nv_rd_o), .nv_data_i(nv_data_i), .nv_valid_i(nv_valid_i),
        .cal_16m_i(cal_16m_i), .cal_20m_i(cal_20m_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .osc_o(osc_o), .timer_o(timer_o),
        .compare_raw_i(compare_raw_i), .fault_detect_flag_i(fault_detect_flag_i), .debug_entry_i(debug_entry_i),
        .compare_pin_o(compare_pin_o), .compare_pin_oe_o(compare_pin_oe_o), .crc_scan_source_o(crc_scan_source_o),
        .reset_pin_function_o(reset_pin_function_o), .gpio_drive_allow_o(gpio_drive_allow_o),
        .chip_erase_i(chip_erase_i), .eeprom_erase_o(eeprom_erase_o),
        .startup_delay_select_o(startup_delay_select_o), .startup_done_o(startup_done_o),
        .flash_map_o(flash_map_o), .device_locked_o(device_locked_o), .prog_bus_req_i(prog_bus_req_i),
        .prog_bus_grant_o(prog_bus_grant_o), .load_done_o(load_done_o));
    nv_store_model nv_store_model_i (.clk_i(clk_i), .rd_i(nv_rd_o), .addr_i(nv_addr_o), .bytes_i(fz),
        .delay_i(dly), .data_o(nv_data_i), .valid_o(nv_valid_i));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wait_n(input int lim);
        if (n >= lim) begin
            err_count++;
            stop_test();
        end
    endtask

    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        n = 0;
        do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        wait_n(20);
    endtask

    task automatic load(input logic p);
        @(posedge clk_i);
        rst_i <= 1'b1;
        por_i <= p;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        t0 = cyc_n;
        n = 0;
        do begin @(posedge clk_i); n++; end while (load_done_o !== 1'b1 && n < 2000);
        wait_n(2000);
        repeat (2) @(posedge clk_i);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        load(1'b1);
        chk("osc", osc_o, {1'b1, 2'h2, 1'b0, 7'h6A, 4'hC});
        chk("tmr", timer_o, 8'hA5);
        chk("crc", crc_scan_source_o, fuse_config_pkg::CRC_FULL_FLASH);
        chk("rpin", reset_pin_function_o, fuse_config_pkg::PIN_GPIO);
        chk("map", flash_map_o, {8'h10, 8'h20, 2'b00});
        chk("lock", {device_locked_o, prog_bus_grant_o}, 2'b01);
        chk("sut", {startup_delay_select_o, startup_done_o}, 4'h1);
        chk("pin", {compare_pin_oe_o, compare_pin_o, gpio_drive_allow_o}, 9'h15E);
        debug_entry_i <= 1'b1;
        fault_detect_flag_i <= 1'b1;
        chip_erase_i <= 1'b1;
        @(posedge clk_i);
        chk("dbg", {compare_pin_o, eeprom_erase_o}, 5'h0A);
        debug_entry_i <= 1'b0;
        for (int i = 0; i < 11; i++) begin
            wb(8'(4 * i), 1'b0, 32'h0);
            chk("fuse", q, {24'h0, fz[i]});
        end
        wb(8'h08, 1'b1, 32'hFF);
        wb(8'h08, 1'b0, 32'h0);
        chk("ro", q, 32'h82);
        wb(8'h80, 1'b0, 32'h0);
        chk("unmap", q, 32'h0);
        wb(8'h40, 1'b0, 32'h0);
        chk("status", q, 32'h32);
        wb(8'h44, 1'b0, 32'h0);
        chk("ctrl", q, 32'h5);
        wb(8'h48, 1'b0, 32'h0);
        chk("cal", q, {21'h0, 7'h6A, 4'hC});
        wb(8'h28, 1'b1, 32'h0);
        @(posedge clk_i);
        chk("lockw", {device_locked_o, prog_bus_grant_o, eeprom_erase_o}, 3'b101);
        wb(8'h28, 1'b1, 32'hC5);
        @(posedge clk_i);
        chk("open", device_locked_o, 1'b0);
        prog_bus_req_i <= 1'b0;
        @(posedge clk_i);
        chk("nogrant", prog_bus_grant_o, 1'b0);
        prog_bus_req_i <= 1'b1;
        n = 0;
        // Software side: pin interrupts wait until the pin may drive
        while (gpio_drive_allow_o !== 1'b1 && n < 8000) begin @(posedge clk_i); n++; end
        wait_n(8000);
        chk("hold", (cyc_n - t0) inside {[6130:6170]}, 1'b1);
        fz[2] = 8'h01;
        fz[4] = 8'h3C;
        fz[5] = 8'h44;
        fz[8:7] = 16'h0;
        dly = 4'h0;
        load(1'b0);
        chk("tmr2", timer_o, 8'hA5);
        chk("osc2", osc_o, {1'b0, 2'h1, 1'b0, 7'h15, 4'h3});
        chk("cfg2", {crc_scan_source_o, reset_pin_function_o, eeprom_erase_o}, 5'b01011);
        chk("map2", flash_map_o, 18'h3);
        fz[2] = 8'h03;
        fz[5] = 8'hC8;
        fz[10] = 8'h12;
        load(1'b1);
        chk("tmr3", timer_o, 8'h3C);
        chk("osc3", osc_o, {1'b0, 2'h3, 1'b1, 7'h6A, 4'hC});
        chk("cfg3", {crc_scan_source_o, reset_pin_function_o, device_locked_o, prog_bus_grant_o}, 6'b111010);
        fz[5] = 8'h8C;
        load(1'b0);
        chk("cfg4", {crc_scan_source_o, reset_pin_function_o}, 4'b1011);
        stop_test();
    end
endmodule
